// [common/lsoc_pkg.sv]
// shared constants and types for the locked sequence and override control
package lsoc_pkg;
    localparam int LSOC_CNT_W = 3;
    localparam logic [2:0] LSOC_CNT_MAX = 3'h4;
    localparam logic [2:0] LSOC_CNT_ZERO = 3'h0;
    localparam int LSOC_DPP_N = 4;
    localparam int LSOC_PAGE_W = 10;
    localparam int LSOC_SEG_W = 8;
    localparam int LSOC_OFS_PAGE_W = 14;
    localparam int LSOC_OFS_SEG_W = 16;
    localparam int LSOC_ADDR_W = 24;
    localparam int LSOC_PRIO_W = 4;
    localparam int LSOC_VEC_W = 7;
    localparam logic [9:0] LSOC_PAGE_RST = 10'h000;
    localparam logic [7:0] LSOC_SEG_RST = 8'h00;
    localparam logic [3:0] LSOC_PRIO_RST = 4'h0;
    localparam logic [6:0] LSOC_VEC_RST = 7'h00;
    // extension instruction kinds
    typedef enum logic [2:0] {
        LSOC_EXT_NONE,
        LSOC_EXT_LOCK,
        LSOC_EXT_PAGE,
        LSOC_EXT_SEG,
        LSOC_EXT_REG,
        LSOC_EXT_PAGE_REG,
        LSOC_EXT_SEG_REG
    } lsoc_ext_type;
endpackage : lsoc_pkg

// [design/lsoc_ext_counter.sv]
// extension counter shared by lock and override instructions
`timescale 1ns/1ps
`default_nettype none
module lsoc_ext_counter
    import lsoc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic load,
    input wire logic [2:0] load_cnt,
    input wire logic done,
    output logic [2:0] cnt_q,
    output logic active
);
    logic [2:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = load_cnt;
        end else if (done && cnt_q != LSOC_CNT_ZERO) begin
            cnt_d = cnt_q - 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_q <= LSOC_CNT_ZERO;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end

    assign active = load || (cnt_q != LSOC_CNT_ZERO);
endmodule : lsoc_ext_counter
`default_nettype wire

// [design/lsoc_addr_gen.sv]
// data address formation with page and segment overrides
`timescale 1ns/1ps
`default_nettype none
module lsoc_addr_gen
    import lsoc_pkg::*;
(
    input wire logic [15:0] op_addr,
    input wire logic [9:0] dpp0,
    input wire logic [9:0] dpp1,
    input wire logic [9:0] dpp2,
    input wire logic [9:0] dpp3,
    input wire logic page_ovr,
    input wire logic [9:0] page_val,
    input wire logic seg_ovr,
    input wire logic [7:0] seg_val,
    output logic [23:0] phys_addr
);
    logic [9:0] sel_page;

    always_comb begin
        sel_page = LSOC_PAGE_RST;
        // pointer picked by top two bits
        unique case (op_addr[15:14])
            2'h0: sel_page = dpp0;
            2'h1: sel_page = dpp1;
            2'h2: sel_page = dpp2;
            2'h3: sel_page = dpp3;
        endcase
        phys_addr = {sel_page, op_addr[13:0]};
        if (seg_ovr) begin
            phys_addr = {seg_val, op_addr};
        end else if (page_ovr) begin
            phys_addr = {page_val, op_addr[13:0]};
        end
    end
endmodule : lsoc_addr_gen
`default_nettype wire

// [design/lsoc_ctrl.sv]
// locked sequence, override and trap/interrupt entry control
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - lock shields next 1..4 instructions
// - class B traps still taken
// - inhibit starts right after lock
// - multi-cycle instruction counts once
// - any opcode allowed inside sequence
// - page pointer plus 14-bit offset
// - page override for 1..4 instructions
// - segment override uses 16-bit offset
// - page/segment overrides inhibit like lock
// - register override selects extended space
// - combined overrides do both, inhibit
// - nested extension reloads counter
// - no transfers in idle when locked
// - multiply/divide interruptible outside sequences
// - interrupt needs strictly higher priority
// - traps ignore cpu priority
// - entry pushes state, branches vector
// - return restores state and resumes
module lsoc_ctrl
    import lsoc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic EXT_VALID,
    input wire lsoc_pkg::lsoc_ext_type EXT_KIND,
    input wire logic [2:0] EXT_COUNT,
    input wire logic [9:0] EXT_PAGE,
    input wire logic [7:0] EXT_SEG,
    input wire logic INSTR_DONE,
    input wire logic INSTR_MULTI,
    input wire logic IDLE_ENTER,
    input wire logic IDLE_WAKE,
    input wire logic RETURN_FROM_INTERRUPT_INSTR_EXEC,
    input wire logic [15:0] OP_ADDR,
    input wire logic [9:0] DPP0,
    input wire logic [9:0] DPP1,
    input wire logic [9:0] DPP2,
    input wire logic [9:0] DPP3,
    input wire logic [3:0] CPU_PRIO,
    input wire logic IRQ_REQ,
    input wire logic [3:0] IRQ_PRIO,
    input wire logic [6:0] IRQ_VEC,
    input wire logic PEC_REQ,
    input wire logic TRAPA_REQ,
    input wire logic [6:0] TRAPA_VEC,
    input wire logic TRAPB_REQ,
    input wire logic [6:0] TRAPB_VEC,
    output logic LOCKED,
    output logic REG_EXT_SPACE,
    output logic [23:0] DATA_ADDR,
    output logic MULDIV_INTERRUPTIBLE,
    output logic IRQ_TAKE,
    output logic PEC_TAKE,
    output logic TRAP_TAKE,
    output logic PUSH_STATE,
    output logic POP_STATE,
    output logic VEC_LOAD,
    output logic [6:0] VEC_NUM,
    output logic IN_SERVICE
);
    logic [2:0] cnt_q;
    logic active;
    logic load;
    logic done;
    logic page_ovr_q;
    logic seg_ovr_q;
    logic reg_ovr_q;
    logic [9:0] page_q;
    logic [7:0] seg_q;
    logic idle_locked_q;
    logic [3:0] depth_q;
    logic [23:0] addr_c;
    logic irq_ok;
    logic inhibit;

    // count 0 from the pipeline means maximum run
    function automatic logic [2:0] lsoc_norm_cnt(input logic [2:0] c);
        lsoc_norm_cnt = (c == LSOC_CNT_ZERO || c > LSOC_CNT_MAX) ? LSOC_CNT_MAX : c;
    endfunction

    // ==================================================
    // extension counter
    // load accepted for every kind except none
    assign load = CE && EXT_VALID && EXT_KIND != LSOC_EXT_NONE;
    assign done = INSTR_DONE && !EXT_VALID;

    lsoc_ext_counter u_cnt (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .load(load),
        .load_cnt(lsoc_norm_cnt(EXT_COUNT)),
        .done(done),
        .cnt_q(cnt_q),
        .active(active)
    );

    // ==================================================
    // override state
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            page_ovr_q <= 1'b0;
            seg_ovr_q <= 1'b0;
            reg_ovr_q <= 1'b0;
            page_q <= LSOC_PAGE_RST;
            seg_q <= LSOC_SEG_RST;
        end else if (CE) begin
            if (load) begin
                page_ovr_q <= EXT_KIND == LSOC_EXT_PAGE || EXT_KIND == LSOC_EXT_PAGE_REG;
                seg_ovr_q <= EXT_KIND == LSOC_EXT_SEG || EXT_KIND == LSOC_EXT_SEG_REG;
                reg_ovr_q <= EXT_KIND == LSOC_EXT_REG || EXT_KIND == LSOC_EXT_PAGE_REG
                             || EXT_KIND == LSOC_EXT_SEG_REG;
                page_q <= EXT_PAGE;
                seg_q <= EXT_SEG;
            end else if (done && cnt_q == 3'h1) begin
                page_ovr_q <= 1'b0;
                seg_ovr_q <= 1'b0;
                reg_ovr_q <= 1'b0;
            end
        end
    end

    lsoc_addr_gen u_addr (
        .op_addr(OP_ADDR),
        .dpp0(DPP0),
        .dpp1(DPP1),
        .dpp2(DPP2),
        .dpp3(DPP3),
        .page_ovr(page_ovr_q),
        .page_val(page_q),
        .seg_ovr(seg_ovr_q),
        .seg_val(seg_q),
        .phys_addr(addr_c)
    );

    // ==================================================
    // idle inside a locked run
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            idle_locked_q <= 1'b0;
        end else if (CE) begin
            if (IDLE_ENTER && active) begin
                idle_locked_q <= 1'b1;
            end else if (IDLE_WAKE) begin
                idle_locked_q <= 1'b0;
            end
        end
    end

    // ==================================================
    // arbitration
    // every kind inhibits alike
    assign inhibit = active || idle_locked_q;
    assign irq_ok = IRQ_REQ && (IRQ_PRIO > CPU_PRIO);

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            IRQ_TAKE <= 1'b0;
            PEC_TAKE <= 1'b0;
            TRAP_TAKE <= 1'b0;
            PUSH_STATE <= 1'b0;
            VEC_LOAD <= 1'b0;
            VEC_NUM <= LSOC_VEC_RST;
        end else if (CE) begin
            IRQ_TAKE <= 1'b0;
            PEC_TAKE <= 1'b0;
            TRAP_TAKE <= 1'b0;
            PUSH_STATE <= 1'b0;
            VEC_LOAD <= 1'b0;
            // class B breaks a locked run
            if (TRAPB_REQ) begin
                TRAP_TAKE <= 1'b1;
                PUSH_STATE <= 1'b1;
                VEC_LOAD <= 1'b1;
                VEC_NUM <= TRAPB_VEC;
            end else if (TRAPA_REQ && !inhibit) begin
                TRAP_TAKE <= 1'b1;
                PUSH_STATE <= 1'b1;
                VEC_LOAD <= 1'b1;
                VEC_NUM <= TRAPA_VEC;
            end else if (irq_ok && !inhibit) begin
                IRQ_TAKE <= 1'b1;
                PUSH_STATE <= 1'b1;
                VEC_LOAD <= 1'b1;
                VEC_NUM <= IRQ_VEC;
            // transfers steal a cycle, no stack frame
            end else if (PEC_REQ && !inhibit) begin
                PEC_TAKE <= 1'b1;
            end
        end
    end

    // ==================================================
    // return and service depth
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            POP_STATE <= 1'b0;
            depth_q <= 4'h0;
        end else if (CE) begin
            POP_STATE <= RETURN_FROM_INTERRUPT_INSTR_EXEC && depth_q != 4'h0;
            if (PUSH_STATE && !(RETURN_FROM_INTERRUPT_INSTR_EXEC && depth_q != 4'h0)) begin
                depth_q <= depth_q + 4'h1;
            end else if (!PUSH_STATE && RETURN_FROM_INTERRUPT_INSTR_EXEC && depth_q != 4'h0) begin
                depth_q <= depth_q - 4'h1;
            end
        end
    end

    // ==================================================
    // registered outputs
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            LOCKED <= 1'b0;
            REG_EXT_SPACE <= 1'b0;
            DATA_ADDR <= 24'h000000;
            MULDIV_INTERRUPTIBLE <= 1'b1;
            IN_SERVICE <= 1'b0;
        end else if (CE) begin
            LOCKED <= inhibit;
            REG_EXT_SPACE <= reg_ovr_q;
            DATA_ADDR <= addr_c;
            MULDIV_INTERRUPTIBLE <= !(inhibit && INSTR_MULTI) && !inhibit;
            IN_SERVICE <= depth_q != 4'h0;
        end
    end
endmodule : lsoc_ctrl
`default_nettype wire

// [dv/lsoc_irq_model.sv]
// far-side request model: interrupt, transfer and trap sources
`timescale 1ns/1ps
`default_nettype none
module lsoc_irq_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] set,
    input wire logic irq_take,
    input wire logic pec_take,
    input wire logic trap_take,
    output logic irq_req,
    output logic pec_req,
    output logic trapa_req,
    output logic trapb_req
);
    // pending bits: irq, transfer, class a, class b
    logic [3:0] pend_q;
    logic [3:0] took;
    // class b owns a shared trap take while it is pending
    assign took = {irq_take, pec_take, trap_take & ~pend_q[0], trap_take & pend_q[0]};
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pend_q <= 4'h0;
        end else begin
            pend_q <= set | (pend_q & ~took);
        end
    end
    // drop as the take shows, otherwise a level request is served twice
    assign {irq_req, pec_req, trapa_req, trapb_req} = pend_q & ~took;
endmodule // lsoc_irq_model
`default_nettype wire

// [dv/lsoc_ctrl_asserts.sv]
// assertion checker for the locked sequence and override control
`timescale 1ns/1ps
`default_nettype none
module lsoc_ctrl_asserts
    import lsoc_pkg::*;
(
    input wire logic CLK, RST_B, CE, EXT_VALID, INSTR_DONE, IDLE_ENTER, IDLE_WAKE, RETURN_FROM_INTERRUPT_INSTR_EXEC,
    input wire lsoc_pkg::lsoc_ext_type EXT_KIND,
    input wire logic [2:0] EXT_COUNT,
    input wire logic [3:0] CPU_PRIO, IRQ_PRIO,
    input wire logic [6:0] IRQ_VEC, TRAPB_VEC, VEC_NUM,
    input wire logic IRQ_REQ, TRAPA_REQ, TRAPB_REQ, LOCKED, IRQ_TAKE, PEC_TAKE, TRAP_TAKE, POP_STATE, IN_SERVICE
);
    logic [2:0] rem_q;
    logic idle_q;
    logic go;
    assign go = CE && EXT_VALID && EXT_KIND != LSOC_EXT_NONE;
    // ========
    // reference run length; 0 or above 4 loads 4
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rem_q <= LSOC_CNT_ZERO;
        end else if (go) begin
            rem_q <= (EXT_COUNT == LSOC_CNT_ZERO || EXT_COUNT > LSOC_CNT_MAX) ? LSOC_CNT_MAX : EXT_COUNT;
        end else if (CE && INSTR_DONE && rem_q != LSOC_CNT_ZERO) begin
            rem_q <= rem_q - 3'h1;
        end
    end
    always_ff @(posedge CLK) begin
        if (!RST_B || (CE && IDLE_WAKE)) begin
            idle_q <= 1'b0;
        end else if (CE && IDLE_ENTER && LOCKED) begin
            idle_q <= 1'b1;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    lock_start_a: assert property (go |=> LOCKED && !IRQ_TAKE && !PEC_TAKE)
        else $error("lock late");
    // lock output is registered, so it follows the count of the cycle before
    run_length_a: assert property (!idle_q && !$past(idle_q)
        |-> LOCKED == ($past(rem_q) != LSOC_CNT_ZERO || $past(go)))
        else $error("lock length wrong");
    hold_off_a: assert property (CE && LOCKED && (rem_q != LSOC_CNT_ZERO || idle_q) && !TRAPB_REQ && !IDLE_WAKE
        && !(INSTR_DONE && rem_q == 3'h1) |=> !IRQ_TAKE && !PEC_TAKE && !TRAP_TAKE)
        else $error("take inside lock");
    class_b_a: assert property (CE && TRAPB_REQ |=> TRAP_TAKE && VEC_NUM == $past(TRAPB_VEC))
        else $error("class b trap missed");
    prio_refuse_a: assert property (CE && IRQ_REQ && IRQ_PRIO <= CPU_PRIO |=> !IRQ_TAKE)
        else $error("low priority taken");
    irq_entry_a: assert property (CE && IRQ_REQ && IRQ_PRIO > CPU_PRIO && !LOCKED && !go
        && !TRAPA_REQ && !TRAPB_REQ |=> IRQ_TAKE && VEC_NUM == $past(IRQ_VEC))
        else $error("interrupt entry missed");
    return_from_interrupt_instr_pop_a: assert property (CE && RETURN_FROM_INTERRUPT_INSTR_EXEC |=> POP_STATE == $past(IN_SERVICE))
        else $error("return pop wrong");
    idle_hold_a: assert property (CE && idle_q && !IDLE_WAKE |=> !PEC_TAKE)
        else $error("transfer during idle");
    cover property (go ##1 LOCKED);
    cover property (LOCKED && TRAP_TAKE);
    cover property (RETURN_FROM_INTERRUPT_INSTR_EXEC ##1 POP_STATE);
endmodule // lsoc_ctrl_asserts
bind lsoc_ctrl lsoc_ctrl_asserts u_chk (.*);
`default_nettype wire

// [dv/lsoc_ctrl_test.sv]
// self-checking bench for the locked sequence and override control
`timescale 1ns/1ps
`default_nettype none
module lsoc_ctrl_test;
    import lsoc_pkg::*;
    logic CLK, RST_B, CE, EXT_VALID, INSTR_DONE, INSTR_MULTI, IDLE_ENTER, IDLE_WAKE, RETURN_FROM_INTERRUPT_INSTR_EXEC, PEC_REQ;
    logic IRQ_REQ, TRAPA_REQ, TRAPB_REQ, LOCKED, REG_EXT_SPACE, MULDIV_INTERRUPTIBLE, IRQ_TAKE, PEC_TAKE;
    logic TRAP_TAKE, PUSH_STATE, POP_STATE, VEC_LOAD, IN_SERVICE;
    lsoc_ext_type EXT_KIND;
    logic [2:0] EXT_COUNT;
    logic [3:0] CPU_PRIO, IRQ_PRIO, setq;
    logic [6:0] IRQ_VEC, TRAPA_VEC, TRAPB_VEC, VEC_NUM;
    logic [7:0] EXT_SEG;
    logic [9:0] EXT_PAGE, DPP0, DPP1, DPP2, DPP3;
    logic [15:0] OP_ADDR;
    logic [23:0] DATA_ADDR;
    logic [31:0] lf = 32'd66740;
    int fail_count, checks, n_irq, n_pec, n_trap, n_pop, k, c, n0, i;
    lsoc_ctrl DUT (.*);
    lsoc_irq_model u_far (.clk(CLK), .rst_b(RST_B), .set(setq), .irq_take(IRQ_TAKE), .pec_take(PEC_TAKE),
        .trap_take(TRAP_TAKE), .irq_req(IRQ_REQ), .pec_req(PEC_REQ), .trapa_req(TRAPA_REQ), .trapb_req(TRAPB_REQ));
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        if (IRQ_TAKE === 1'b1) n_irq++;
        if (PEC_TAKE === 1'b1) n_pec++;
        if (TRAP_TAKE === 1'b1) n_trap++;
        if (POP_STATE === 1'b1) n_pop++;
    end
    // ========
    function logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    function logic [23:0] ea(input int kd, input logic [15:0] a);
        logic [1:0] s;
        s = a[15:14];
        if (kd == 3 || kd == 6) return {EXT_SEG, a};
        if (kd == 2 || kd == 5) return {EXT_PAGE, a[13:0]};
        return {s == 2'h0 ? DPP0 : s == 2'h1 ? DPP1 : s == 2'h2 ? DPP2 : DPP3, a[13:0]};
    endfunction
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task summarize();
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // inputs change 1 ns after the edge, so outputs are settled when read
    task cy(input int n = 1);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task ext(input int kd, input int cn);
        EXT_VALID <= 1'b1;
        EXT_KIND <= lsoc_ext_type'(kd);
        EXT_COUNT <= 3'(cn);
        cy();
        EXT_VALID <= 1'b0;
    endtask
    task done();
        INSTR_MULTI <= 1'b1;
        cy();
        {INSTR_MULTI, INSTR_DONE} <= 2'b01;
        cy();
        INSTR_DONE <= 1'b0;
    endtask
    // whole run is under two hundred cycles
    initial begin
        cy(3000);
        fail_count++;
        summarize();
    end
    initial begin
        {RST_B, EXT_VALID, INSTR_DONE, INSTR_MULTI, IDLE_ENTER, IDLE_WAKE, RETURN_FROM_INTERRUPT_INSTR_EXEC, setq} = '0;
        {CE, EXT_KIND, EXT_COUNT, EXT_PAGE, EXT_SEG, OP_ADDR, DPP0, DPP1, DPP2, DPP3} = {1'b1, 80'h0};
        {CPU_PRIO, IRQ_PRIO, IRQ_VEC, TRAPA_VEC, TRAPB_VEC} = '0;
        cy(8);
        chk({LOCKED, MULDIV_INTERRUPTIBLE, IN_SERVICE, VEC_NUM, DATA_ADDR}, {3'b010, 31'h0});
        RST_B <= 1'b1;
        for (i = 0; i < 24; i++) begin
            {DPP0, DPP1, DPP2, DPP3} <= 40'({rnd(), rnd()});
            OP_ADDR <= {2'(i), 14'(rnd())};
            cy();
            chk(DATA_ADDR, ea(0, OP_ADDR));
        end
        for (k = 1; k < 7; k++) begin
            c = 1 + rnd() % 4;
            n0 = n_irq;
            {EXT_PAGE, EXT_SEG, OP_ADDR} <= 34'({rnd(), rnd()});
            {IRQ_PRIO, IRQ_VEC} <= {4'h1 + 4'(rnd() % 15), 7'(rnd())};
            setq <= 4'h8;
            cy();
            setq <= 4'h0;
            ext(k, c);
            chk(LOCKED, 1'b1);
            cy();
            // extended space flag is registered one cycle after the override state
            chk({REG_EXT_SPACE, DATA_ADDR}, {k >= 4, ea(k, OP_ADDR)});
            repeat (c) begin
                chk({LOCKED, MULDIV_INTERRUPTIBLE}, 2'b10);
                done();
            end
            // lock output drops one cycle after the last completion
            cy();
            chk({LOCKED, 28'(n_irq)}, {1'b0, 28'(n0)});
            cy();
            chk({VEC_NUM, 28'(n_irq)}, {IRQ_VEC, 28'(n0 + 1)});
        end
        n0 = n_irq;
        setq <= 4'h8;
        ext(1, 2);
        setq <= 4'h0;
        done();
        ext(2, 3);
        repeat (3) begin
            chk(LOCKED, 1);
            done();
        end
        cy();
        chk({LOCKED, 28'(n_irq)}, {1'b0, 28'(n0)});
        n0 = n_trap;
        {CPU_PRIO, TRAPA_VEC, TRAPB_VEC} <= {4'hf, 14'(rnd())};
        ext(1, 4);
        setq <= 4'h3;
        cy();
        setq <= 4'h0;
        cy(3);
        chk({VEC_NUM, 28'(n_trap)}, {TRAPB_VEC, 28'(n0 + 1)});
        repeat (4) done();
        cy(2);
        chk({VEC_NUM, 28'(n_trap)}, {TRAPA_VEC, 28'(n0 + 2)});
        n0 = n_irq;
        c = rnd() % 15;
        {CPU_PRIO, IRQ_PRIO, setq} <= {4'(c), 4'(c), 4'h8};
        cy();
        setq <= 4'h0;
        cy(4);
        chk(n_irq, n0);
        IRQ_PRIO <= 4'(c + 1);
        cy(3);
        chk(n_irq, n0 + 1);
        n0 = n_pec;
        ext(1, 1);
        {IDLE_ENTER, setq} <= {1'b1, 4'h4};
        cy();
        {IDLE_ENTER, setq} <= 5'h0;
        done();
        cy(4);
        chk(n_pec, n0);
        IDLE_WAKE <= 1'b1;
        cy();
        IDLE_WAKE <= 1'b0;
        cy(3);
        chk(n_pec, n0 + 1);
        n0 = n_pop;
        c = n_irq + n_trap;
        repeat (c + 1) begin
            RETURN_FROM_INTERRUPT_INSTR_EXEC <= 1'b1;
            cy();
            RETURN_FROM_INTERRUPT_INSTR_EXEC <= 1'b0;
            cy();
        end
        chk({IN_SERVICE, 28'(n_pop)}, {1'b0, 28'(n0 + c)});
        summarize();
    end
endmodule // lsoc_ctrl_test
`default_nettype wire
